// ---- cvam_pkg.sv ----
// Constants and types for the converter alarm manager.
// Assumes a single 200 MHz control clock and a power-on reset.
// Notes on behaviour
// (R1) Any active alarm drops fault_output; the lowest-index active alarm shows its code on the display.
// (R2) Power cycle clears every alarm; power-on starts with nothing latched.
// (R3) Only A.10, A.30, A.33, A.45, A.50, A.51 clear by key or fault_clear_input.
// (R4) A.30, A.45, A.50, A.51 also clear by host error-reset command.
// (R5) Control power lost longer than 60ms raises A.10.
// (R6) Parameter memory writes past 100,000 raise A.15.
// (R7) Warnings shown: A.91, A.E0, A.E1, A.E6, A.E8.
// (R8) Other alarm codes: A.12, A.15, A.17, A.19, A.37, A.38, A.39, A.3A, A.47, 888.
// (R9) Host should wait about 30 minutes cooling before resetting thermal alarms.
// (R10) A raised alarm stays latched with its code until a permitted clear.
package cvam_pkg;
    localparam int CLK_MHZ = 200;
    localparam int PWR_LOSS_MS = 60;
    localparam int PWR_LOSS_CYCLES = PWR_LOSS_MS * 1000 * CLK_MHZ;
    localparam int NVM_WRITE_LIMIT = 100000;
    localparam int NUM_ALARMS = 16;
    localparam int NUM_WARNS = 5;
    localparam logic [11:0] CODE_NONE = 12'h000;

    // Display codes, index order is also priority order (lowest wins)
    localparam logic [11:0] ALARM_CODE [NUM_ALARMS] = '{
        12'h010, 12'h012, 12'h015, 12'h017, 12'h019, 12'h030, 12'h033, 12'h037,
        12'h038, 12'h039, 12'h03a, 12'h045, 12'h047, 12'h050, 12'h051, 12'h888};
    // Cleared by reset key or fault_clear_input
    localparam logic [NUM_ALARMS-1:0] KEY_CLEAR_MASK = 16'h6861;
    // Cleared by host error-reset command
    localparam logic [NUM_ALARMS-1:0] HOST_CLEAR_MASK = 16'h6820;
    localparam logic [11:0] WARN_CODE [NUM_WARNS] = '{
        12'h091, 12'h0e0, 12'h0e1, 12'h0e6, 12'h0e8};

    // Alarm index names
    localparam int IDX_UNDERVOLT = 0;
    localparam int IDX_NVM = 2;

    typedef struct packed {
        logic [NUM_ALARMS-1:0] alarm;
        logic [NUM_WARNS-1:0] warn;
    } cvam_det_t;

    typedef struct packed {
        logic is_alarm;
        logic is_warn;
        logic [11:0] code;
    } cvam_disp_t;
endpackage

// ---- cvam_sync.sv ----
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes inputs are quasi-static relative to clk.
`timescale 1ns/1ps
module cvam_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ---- cvam_top.sv ----
// Alarm latching, clearing and display code selection for the converter.
// Raw monitor levels become latched alarms; each clear source may release only
// the alarms it is allowed to, and the display shows one code at a time.
// Assumes monitor, power, write and clear inputs are asynchronous levels,
// and that rst_n is the power-on reset, the one event that clears every alarm.
`timescale 1ns/1ps
module cvam_top #(
    parameter int PWR_LOSS_CYCLES = cvam_pkg::PWR_LOSS_CYCLES,
    parameter int NVM_WRITE_LIMIT = cvam_pkg::NVM_WRITE_LIMIT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire cvam_pkg::cvam_det_t det_in,
    input wire logic ctrl_power_ok,
    input wire logic nvm_write,
    input wire logic reset_key,
    input wire logic fault_clear_input,
    input wire logic host_err_reset,
    output logic fault_output,
    output cvam_pkg::cvam_disp_t disp
);
    // Synchronised bundle: the monitors plus five control levels
    localparam int IW = cvam_pkg::NUM_ALARMS + cvam_pkg::NUM_WARNS + 5;
    // Bundle layout, msb first: monitors, power ok, write, key, clear input, host reset

    // Synchronised copies of the pins
    logic [IW-1:0] sync_q;
    cvam_pkg::cvam_det_t det;
    logic pwr_ok;
    logic nvm_wr;
    logic key;
    logic clr_in;
    logic host_rst;

    // Delayed copies for edge detection, and the one-cycle pulses
    logic nvm_wr_d;
    logic key_d;
    logic clr_in_d;
    logic host_d;
    logic nvm_rise;
    logic key_rise;
    logic clr_in_rise;
    logic host_rise;
    logic local_clear;

    // Internally derived alarm sources
    logic [31:0] loss_cnt;
    logic [16:0] nvm_cnt;
    logic uv_trip;
    logic nvm_trip;

    // Alarm latch and what feeds it
    logic [cvam_pkg::NUM_ALARMS-1:0] raise;
    logic [cvam_pkg::NUM_ALARMS-1:0] clear_key;
    logic [cvam_pkg::NUM_ALARMS-1:0] clear_host;
    logic [cvam_pkg::NUM_ALARMS-1:0] latched;
    logic any_latched;

    // Display selection
    cvam_pkg::cvam_disp_t next_disp;

    // All pins arrive from outside the clock domain and pass two flops first.
    // Power reads as lost for two cycles after reset, far below the limit.
    cvam_sync #(.W(IW)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({det_in, ctrl_power_ok, nvm_write, reset_key, fault_clear_input, host_err_reset}),
        .q(sync_q)
    );

    // Unpack in the order the bundle was packed above
    assign det = sync_q[IW-1:5];
    assign pwr_ok = sync_q[4];
    assign nvm_wr = sync_q[3];
    assign key = sync_q[2];
    assign clr_in = sync_q[1];
    assign host_rst = sync_q[0];

    // Counts cycles of missing control power; restarts when power returns.
    // Stops one past the limit so a long outage never wraps it back to zero.
    // Dips up to the limit are ridden through without any alarm.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loss_cnt <= '0;
        end else if (pwr_ok) begin
            loss_cnt <= '0;
        end else if (loss_cnt <= 32'(PWR_LOSS_CYCLES)) begin
            loss_cnt <= loss_cnt + 32'h1;
        end
    end

    // Undervoltage once the outage lasts longer than the limit
    assign uv_trip = loss_cnt > 32'(PWR_LOSS_CYCLES); // R5

    // Write strobe delay; a write held high counts once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nvm_wr_d <= 1'b0;
        end else begin
            nvm_wr_d <= nvm_wr;
        end
    end
    assign nvm_rise = nvm_wr && !nvm_wr_d;

    // Cumulative parameter memory writes, saturating one past the limit.
    // Kept in plain flops, so a power-on restarts the count from zero.
    // The limit is a parameter only so a short run can reach it; keep it below 2^17 - 1.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nvm_cnt <= '0;
        end else if (nvm_rise && nvm_cnt <= 17'(NVM_WRITE_LIMIT)) begin
            nvm_cnt <= nvm_cnt + 17'h1;
        end
    end

    // Memory worn out once the count has passed the limit
    assign nvm_trip = nvm_cnt > 17'(NVM_WRITE_LIMIT); // R6

    // Raise conditions: monitors plus the two internally derived alarms
    always_comb begin
        raise = det.alarm;
        if (uv_trip) begin
            raise[cvam_pkg::IDX_UNDERVOLT] = 1'b1; // R5
        end
        if (nvm_trip) begin
            raise[cvam_pkg::IDX_NVM] = 1'b1; // R6
        end
    end

    // Reset key delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_d <= 1'b0;
        end else begin
            key_d <= key;
        end
    end

    // Clear input delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_in_d <= 1'b0;
        end else begin
            clr_in_d <= clr_in;
        end
    end

    // Host command delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_d <= 1'b0;
        end else begin
            host_d <= host_rst;
        end
    end

    // Clear requests act on their rising edge only, so a held key clears once
    assign key_rise = key && !key_d;
    assign clr_in_rise = clr_in && !clr_in_d;
    assign host_rise = host_rst && !host_d;
    // Panel key and clear input share one permission set
    assign local_clear = key_rise || clr_in_rise;

    // Which alarms each clear pulse may release
    assign clear_key = local_clear ? cvam_pkg::KEY_CLEAR_MASK : '0; // R3
    assign clear_host = host_rise ? cvam_pkg::HOST_CLEAR_MASK : '0; // R4

    // One latch per alarm. A raise in the clear cycle wins, so a clear sent while
    // the cause is still present leaves the alarm standing. Alarms outside both
    // masks have no clear path here and fall only to the power-on reset.
    for (genvar a = 0; a < cvam_pkg::NUM_ALARMS; a++) begin : g_latch
        logic hold;

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                hold <= 1'b0; // R2
            end else if (raise[a]) begin
                hold <= 1'b1; // R10
            end else if (clear_key[a] || clear_host[a]) begin
                hold <= 1'b0; // R3
            end
        end
        assign latched[a] = hold;
    end

    // Any latched alarm pulls the trouble output low
    assign any_latched = |latched;

    // Lowest-index latched alarm first, otherwise the first live warning.
    // Warnings are not latched: they show only while their level stands.
    // The panel has room for one code, so the ranking is a local choice.
    always_comb begin
        next_disp = '{is_alarm: 1'b0, is_warn: 1'b0, code: cvam_pkg::CODE_NONE};
        for (int w = cvam_pkg::NUM_WARNS - 1; w >= 0; w--) begin
            if (det.warn[w]) begin
                next_disp = '{is_alarm: 1'b0, is_warn: 1'b1, code: cvam_pkg::WARN_CODE[w]}; // R7
            end
        end
        for (int a = cvam_pkg::NUM_ALARMS - 1; a >= 0; a--) begin
            if (latched[a]) begin
                next_disp = '{is_alarm: 1'b1, is_warn: 1'b0, code: cvam_pkg::ALARM_CODE[a]}; // R8
            end
        end
    end

    // Trouble output, high means healthy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_output <= 1'b1;
        end else begin
            fault_output <= ~any_latched; // R1
        end
    end

    // Display register, updated in step with the trouble output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            disp <= '0;
        end else begin
            disp <= next_disp; // R1
        end
    end
endmodule

// ---- cvam_checker.sv ----
// Port checker for cvam_top, bound below.
// Assumes 2-flop input sync, 4-cycle answer.
`timescale 1ns/1ps
module cvam_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire cvam_pkg::cvam_det_t det_in,
    input wire logic reset_key,
    input wire logic fault_clear_input,
    input wire logic host_err_reset,
    input wire logic fault_output,
    input wire cvam_pkg::cvam_disp_t disp
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Any clear request
    wire clr = reset_key | fault_clear_input | host_err_reset;
    chk_alarm_drops: assert property ((|det_in.alarm)[*6] |-> !fault_output) else $error("alarm missed");
    chk_flag_match: assert property (fault_output != disp.is_alarm) else $error("flag mismatch");
    chk_alarm_held: assert property (!clr[*4] ##0 !fault_output |=> !fault_output) else $error("alarm lost");
    chk_clear_cause: assert property ($rose(fault_output) |-> $past(clr, 4)) else $error("clear no cause");
    chk_warn_quiet: assert property (disp.is_warn |-> fault_output) else $error("warn on alarm");
    chk_idle_blank: assert property (fault_output && !disp.is_warn |-> disp.code == 12'h000) else $error("stale code");
    chk_uv_code: assert property (det_in.alarm[0][*6] |-> disp.code == 12'h010) else $error("bad A10");
    chk_warn_code: assert property ((det_in.warn[0] && det_in.alarm == 16'h0000)[*6] ##0 fault_output
        |-> disp.code == 12'h091) else $error("bad A91");
endmodule
bind cvam_top cvam_checker chk (.clk, .rst_n, .det_in, .reset_key, .fault_clear_input, .host_err_reset,
    .fault_output, .disp);

// ---- cvam_host.sv ----
// Host model issuing the error-reset command.
// Assumes cmd is a short bench request; drives on the falling clock edge.
`timescale 1ns/1ps
module cvam_host #(
    parameter int COOL = 4
) (
    input wire logic clk,
    input wire logic cmd,
    output logic host_err_reset
);
    // Shortened cooling wait, then a 3-cycle command; one process owns the pin
    initial begin
        host_err_reset = 1'b0;
        forever begin
            @(posedge cmd);
            repeat (COOL) @(negedge clk);
            host_err_reset = 1'b1;
            repeat (3) @(negedge clk);
            host_err_reset = 1'b0;
        end
    end
endmodule

// ---- cvam_tb_top.sv ----
// Bench for cvam_top with the host model.
// Assumes the power-loss count cut to 50 and the write limit cut to 5.
`timescale 1ns/1ps
module cvam_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pwr = 1'b1;
    logic key = 1'b0;
    logic fci = 1'b0;
    logic cmd = 1'b0;
    logic nvm = 1'b0;
    logic hrst;
    logic fo;
    cvam_pkg::cvam_det_t det = '0;
    cvam_pkg::cvam_disp_t dsp;
    int errors = 0;
    int n_tests = 0;
    cvam_top #(.PWR_LOSS_CYCLES(50), .NVM_WRITE_LIMIT(5)) dut (.clk(clk), .rst_n(rst_n), .det_in(det),
        .ctrl_power_ok(pwr), .nvm_write(nvm), .reset_key(key), .fault_clear_input(fci), .host_err_reset(hrst),
        .fault_output(fo), .disp(dsp));
    cvam_host host (.clk(clk), .cmd(cmd), .host_err_reset(hrst));
    initial forever #2.5 clk = ~clk;
    task automatic final_report();
        if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    // Flag and display compared as one word
    task automatic check(string what, logic [14:0] exp);
        n_tests++;
        if ({fo, dsp} !== exp) begin
            errors++;
            $display("wrong value %s exp %h got %h", what, exp, {fo, dsp});
        end
    endtask
    task automatic power_cycle();
        rst_n = 1'b0;
        cyc(8);
        rst_n = 1'b1;
        cyc(2);
    endtask
    // Every alarm: host clear, then key or input clear, then power
    task automatic s_alarms();
        logic [11:0] c;
        for (int i = 0; i < 16; i++) begin
            c = cvam_pkg::ALARM_CODE[i];
            det.alarm[i] = 1'b1;
            cyc(6);
            det.alarm[i] = 1'b0;
            cyc(3);
            check("raise", {3'b010, c});
            cmd = 1'b1;
            cyc(1);
            cmd = 1'b0;
            cyc(12);
            check("host", (16'h6820 >> i & 16'h0001) ? 15'h4000 : {3'b010, c});
            if (i % 2) key = 1'b1;
            else fci = 1'b1;
            cyc(3);
            key = 1'b0;
            fci = 1'b0;
            cyc(6);
            check("key", (16'h6861 >> i & 16'h0001) ? 15'h4000 : {3'b010, c});
            power_cycle();
            check("power", 15'h4000);
        end
    endtask
    task automatic s_warns();
        for (int i = 0; i < 5; i++) begin
            det.warn[i] = 1'b1;
            cyc(6);
            check("warn", {3'b101, cvam_pkg::WARN_CODE[i]});
            det.warn[i] = 1'b0;
            cyc(6);
        end
    endtask
    // Dip shorter than the limit is ignored
    task automatic s_power();
        pwr = 1'b0;
        cyc(40);
        pwr = 1'b1;
        cyc(6);
        check("dip", 15'h4000);
        pwr = 1'b0;
        cyc(70);
        pwr = 1'b1;
        cyc(6);
        check("loss", {3'b010, 12'h010});
    endtask
    // Two alarms and a warning: lowest index shows, warning waits for a clear panel
    task automatic s_prio();
        det.alarm[5] = 1'b1;
        det.alarm[12] = 1'b1;
        det.warn[1] = 1'b1;
        cyc(6);
        check("prio", {3'b010, cvam_pkg::ALARM_CODE[5]});
        det.alarm = '0;
        cmd = 1'b1;
        cyc(1);
        cmd = 1'b0;
        cyc(12);
        check("prio host", {3'b010, cvam_pkg::ALARM_CODE[12]});
        power_cycle();
        cyc(2);
        check("prio warn", {3'b101, cvam_pkg::WARN_CODE[1]});
        det.warn[1] = 1'b0;
        cyc(4);
    endtask
    // Writes up to the limit pass; one more latches an alarm only power clears
    task automatic s_nvm();
        for (int i = 0; i < 6; i++) begin
            if (i == 5) check("nvm ok", 15'h4000);
            nvm = 1'b1;
            cyc(2);
            nvm = 1'b0;
            cyc(2);
        end
        cyc(4);
        check("nvm", {3'b010, cvam_pkg::ALARM_CODE[2]});
        key = 1'b1;
        cyc(2);
        key = 1'b0;
        cyc(6);
        check("nvm key", {3'b010, cvam_pkg::ALARM_CODE[2]});
        power_cycle();
        check("nvm power", 15'h4000);
    endtask
    initial begin
        power_cycle();
        s_alarms();
        s_prio();
        s_warns();
        s_nvm();
        s_power();
        final_report();
    end
endmodule
